// ---- dv/dui_host_model.sv ----
// Host processor model that drives the bus pins of the host-bus and interrupt block.
// Assumes one clock shared with the block; the host moves its pins 1 ns after a rising edge.
`timescale 1ns/1ps
module dui_host_model (
  input  wire logic                       clock,
  output logic                            chipSelectN,
  output logic                            readStrobeN,
  output logic                            writeStrobeN,
  output logic [dui_pkg::ADDR_W-1:0]      registerSelect,
  output logic [dui_pkg::DATA_W-1:0]      dataIn,
  input  wire logic [dui_pkg::DATA_W-1:0] dataOut,
  input  wire logic                       dataOe
);
  // Strobe width and recovery gap cover the minimum pulse and idle times at 10 ns.
  localparam int PULSE_CYC = 23;
  localparam int IDLE_CYC  = 20;
  initial begin
    chipSelectN = 1'h1;
    readStrobeN = 1'h1;
    writeStrobeN = 1'h1;
    registerSelect = 4'h0;
    dataIn = 8'h00;
  end
  // Mode 0 plain, 1 chip select asserts last and negates first, 2 chip select stays off.
  task automatic access(input logic isWrite, input logic [dui_pkg::ADDR_W-1:0] addr,
      input logic [dui_pkg::DATA_W-1:0] wdata, input int mode,
      output logic [dui_pkg::DATA_W-1:0] rdata, output logic oeSeen);
    @(posedge clock);
    #1;
    registerSelect = addr;
    dataIn = wdata;
    readStrobeN = isWrite;
    writeStrobeN = !isWrite;
    chipSelectN = (mode != 0);
    @(posedge clock);
    #1;
    if (mode == 1) chipSelectN = 1'h0;
    repeat (PULSE_CYC) @(posedge clock);
    #1;
    rdata = dataOut;
    oeSeen = dataOe;
    chipSelectN = 1'h1;
    if (mode == 1) begin
      @(posedge clock);
      #1;
    end
    readStrobeN = 1'h1;
    writeStrobeN = 1'h1;
    // Released lines show inverted values so a stale read cannot pass by luck.
    repeat (2) @(posedge clock);
    #1;
    registerSelect = ~registerSelect;
    dataIn = ~dataIn;
    repeat (IDLE_CYC) @(posedge clock);
    #1;
  endtask
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the host-bus and interrupt block.
// Assumes the host model above drives the bus and the bench drives events and input pins.
`timescale 1ns/1ps
module testbench;
  logic                                       clock = 1'h0;
  logic                                       rst = 1'h1;
  logic                                       chipSelectN;
  logic                                       readStrobeN;
  logic                                       writeStrobeN;
  logic [dui_pkg::ADDR_W-1:0]                 registerSelect;
  logic [dui_pkg::DATA_W-1:0]                 dataIn;
  logic [dui_pkg::DATA_W-1:0]                 dataOut;
  logic                                       dataOe;
  logic                                       interruptRequestN;
  logic [dui_pkg::DATA_W-1:0]                 portOut;
  logic [dui_pkg::DATA_W-1:0]                 portOe;
  dui_pkg::dui_evt_s                          events = '0;
  dui_pkg::dui_evt_s                          ev;
  logic [dui_pkg::NUM_CH-1:0][dui_pkg::DATA_W-1:0] receiveHoldingData = {8'hB2, 8'hA1};
  logic [dui_pkg::NUM_IP-1:0]                 inputPins = 7'h00;
  logic [dui_pkg::DATA_W-1:0]                 rd;
  logic                                       oe;
  int                                         miscompares = 0;
  int                                         checkCount = 0;

  always #5 clock = ~clock;

  dui_host_model host (.clock(clock), .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
    .writeStrobeN(writeStrobeN), .registerSelect(registerSelect), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe));

  dui_top dut (.clock(clock), .rst(rst), .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
    .writeStrobeN(writeStrobeN), .registerSelect(registerSelect), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .events(events),
    .receiveHoldingData(receiveHoldingData), .inputPins(inputPins),
    .interruptRequestN(interruptRequestN), .portOut(portOut), .portOe(portOe));

  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic checkBit(input string what, input logic exp, input logic got);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] addr, input logic [7:0] data, input int mode);
    host.access(1'h1, addr, data, mode, rd, oe);
  endtask

  // Every read also proves the bus is driven during the access and released after it.
  task automatic rdCheck(input logic [3:0] addr, input logic [7:0] exp, input int mode);
    host.access(1'h0, addr, 8'h00, mode, rd, oe);
    checkBit("read enable", 1'h1, oe);
    checkByte("read data", exp, rd);
    checkBit("bus release", 1'h0, dataOe);
  endtask

  // Leaves the bench one edge after the flag sets, when the request has had time to follow the flag.
  task automatic pulse(input dui_pkg::dui_evt_s e);
    @(posedge clock);
    #1;
    events = e;
    @(posedge clock);
    #1;
    events = '0;
    @(posedge clock);
    #1;
  endtask

  task automatic waitIrq(input logic exp);
    int n;
    n = 0;
    while (interruptRequestN !== exp && n < dui_pkg::NEG_MAX_CYC) begin
      @(posedge clock);
      #1;
      n++;
    end
    checkBit("request wait", exp, interruptRequestN);
    if (interruptRequestN !== exp) giveVerdict();
  endtask

  initial begin
    repeat (8) @(posedge clock);
    #1;
    rst = 1'h0;
    checkBit("request idle", 1'h1, interruptRequestN);
    checkByte("port idle", 8'hFF, portOut);
    checkByte("port enable idle", 8'hFF, portOe);
    rdCheck(dui_pkg::ADR_STAT_MASK, 8'h00, 0);
    ev = '0;
    ev.counterZero = 1'h1;
    pulse(ev);
    checkBit("masked request", 1'h1, interruptRequestN);
    rdCheck(dui_pkg::ADR_STAT_MASK, 8'h08, 0);
    wr(dui_pkg::ADR_STAT_MASK, 8'h08, 1);
    waitIrq(1'h0);
    wr(dui_pkg::ADR_STAT_MASK, 8'h00, 0);
    checkBit("mask clear", 1'h1, interruptRequestN);
    wr(dui_pkg::ADR_STAT_MASK, 8'hFF, 2);
    checkBit("unselected write", 1'h1, interruptRequestN);
    rdCheck(dui_pkg::ADR_OPRST_CT, 8'h00, 1);
    wr(dui_pkg::ADR_STAT_MASK, 8'hFF, 0);
    rdCheck(dui_pkg::ADR_STAT_MASK, 8'h00, 0);
    for (int i = 0; i < 7; i++) begin
      ev = '0;
      case (i % 4)
        0: ev.txLoaded[i/4] = 1'h1;
        1: ev.rxEvent[i/4] = 1'h1;
        2: ev.breakEvent[i/4] = 1'h1;
        default: ev.counterZero = 1'h1;
      endcase
      pulse(ev);
      checkBit("source request", 1'h0, interruptRequestN);
      rdCheck(dui_pkg::ADR_STAT_MASK, 8'h01 << i, 0);
      case (i % 4)
        0: wr(dui_pkg::CH_HOLD[i/4], 8'h5A, 0);
        1: rdCheck(dui_pkg::CH_HOLD[i/4], receiveHoldingData[i/4], 0);
        2: wr(dui_pkg::CH_CMD[i/4], {dui_pkg::CMD_BRK_RESET, 4'h0}, 0);
        default: rdCheck(dui_pkg::ADR_OPRST_CT, 8'h00, 0);
      endcase
      checkBit("source cleared", 1'h1, interruptRequestN);
    end
    wr(dui_pkg::ADR_CHG_AUX, 8'h0F, 0);
    inputPins = 7'h03;
    waitIrq(1'h0);
    rdCheck(dui_pkg::ADR_STAT_MASK, 8'h80, 0);
    rdCheck(dui_pkg::ADR_CHG_AUX, 8'h33, 0);
    checkBit("change cleared", 1'h1, interruptRequestN);
    rdCheck(dui_pkg::ADR_CHG_AUX, 8'h03, 0);
    rdCheck(dui_pkg::ADR_INPORT, 8'h83, 0);
    rdCheck(4'h7, dui_pkg::UNMAPPED_RD, 0);
    wr(dui_pkg::ADR_OPCFG, 8'h1F, 0);
    ev = '0;
    ev.counterZero = 1'h1;
    pulse(ev);
    checkBit("counter pin", 1'h1, portOe[3]);
    checkBit("counter pin low", 1'h0, portOut[3]);
    rdCheck(dui_pkg::ADR_OPRST_CT, 8'h00, 0);
    checkBit("counter pin off", 1'h0, portOe[3]);
    wr(dui_pkg::ADR_STAT_MASK, 8'h00, 0);
    wr(dui_pkg::ADR_OPCFG, 8'h3F, 0);
    ev = '0;
    ev.rxEvent[0] = 1'h1;
    pulse(ev);
    checkBit("dma pin", 1'h1, portOe[4]);
    checkBit("dma masked request", 1'h1, interruptRequestN);
    rdCheck(dui_pkg::ADR_HOLD_A, 8'hA1, 0);
    checkBit("dma pin off", 1'h0, portOe[4]);
    wr(dui_pkg::ADR_OPCFG, 8'h5F, 0);
    ev = '0;
    ev.txLoaded[1] = 1'h1;
    pulse(ev);
    checkBit("dma tx pin", 1'h1, portOe[7]);
    wr(dui_pkg::CH_HOLD[1], 8'h3C, 0);
    checkBit("dma tx pin off", 1'h0, portOe[7]);
    wr(dui_pkg::ADR_OPCFG, 8'h00, 0);
    wr(dui_pkg::ADR_OPSET, 8'h01, 0);
    checkByte("port set", 8'hFE, portOut);
    checkByte("port enable", 8'hFF, portOe);
    wr(dui_pkg::ADR_OPRST_CT, 8'h01, 0);
    checkByte("port reset", 8'hFF, portOut);
    wr(dui_pkg::ADR_STAT_MASK, 8'hFF, 0);
    ev = '0;
    ev.counterZero = 1'h1;
    pulse(ev);
    checkBit("request before reset", 1'h0, interruptRequestN);
    rst = 1'h1;
    repeat (8) @(posedge clock);
    #1;
    rst = 1'h0;
    checkBit("request after reset", 1'h1, interruptRequestN);
    pulse(ev);
    checkBit("mask cleared by reset", 1'h1, interruptRequestN);
    giveVerdict();
  end
endmodule

// ---- logic/dui_bus_decode.sv ----
// Qualifies the host strobes with chip select and turns them into one-cycle read start and write end controls plus a read active level.
// Assumes bus pins are already synchronous to the clock.
`timescale 1ns/1ps
module dui_bus_decode (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       chipSelectN,
  input  wire logic                       readStrobeN,
  input  wire logic                       writeStrobeN,
  input  wire logic [dui_pkg::ADDR_W-1:0] registerSelect,
  input  wire logic [dui_pkg::DATA_W-1:0] dataIn,
  output dui_pkg::dui_bus_s               bus
);

  typedef struct packed {
    logic                       rdLvl;
    logic                       wrLvl;
    logic [dui_pkg::ADDR_W-1:0] addr;
    logic [dui_pkg::DATA_W-1:0] wdata;
  } dui_dec_s;

  dui_dec_s s_q;
  dui_dec_s s_d;
  logic     rdQual;
  logic     wrQual;

  assign rdQual = !chipSelectN && !readStrobeN;
  assign wrQual = !chipSelectN && !writeStrobeN;

  always_comb begin
    s_d = s_q;
    s_d.rdLvl = rdQual;
    s_d.wrLvl = wrQual;
    // The address only holds shortly after the strobe falls, so it is caught at the start.
    if ((rdQual && !s_q.rdLvl) || (wrQual && !s_q.wrLvl)) begin
      s_d.addr = registerSelect;
    end
    if (wrQual) begin
      s_d.wdata = dataIn;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    bus.rdActive = rdQual && s_q.rdLvl;
    bus.rdStart  = rdQual && !s_q.rdLvl;
    bus.wrEnd    = !wrQual && s_q.wrLvl;
    bus.addr     = bus.rdStart ? registerSelect : s_q.addr;
    bus.wdata    = s_q.wdata;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  rd_start_qual_a: assert property (bus.rdStart |-> !chipSelectN && !readStrobeN)
    else $error("Read start without both select and strobe low.");
  wr_end_first_a: assert property (wrQual ##1 (chipSelectN || writeStrobeN) |-> bus.wrEnd)
    else $error("Write did not end when a qualifying signal rose.");

endmodule

// ---- logic/dui_pkg.sv ----
// Shared constants, field layouts and carrier structs for the host-bus and interrupt block.
// Assumes every input is synchronous to the one 100 MHz clock.
// What this block does
// - Chip select is ANDed with each strobe; last asserted starts, first negated ends.
// - One active-low request asserts when any of eight enabled events is active.
// - Mask register is writable; only unmasked status bits drive the request.
// - Status register reads every active condition regardless of the mask.
// - Status carries one change-of-state summary; per-pin detail lives elsewhere.
// - Reading a channel receive holding register clears its receive interrupt.
// - Writing a channel transmit holding register clears its transmit-ready interrupt.
// - The reset-break channel command clears that channel's break interrupt.
// - The stop counter command clears the counter interrupt.
// - Reading the input change register clears the change-of-state interrupt.
// - Clearing a mask bit removes that source from the request at once.
// - Output pins three to seven can be discrete counter, receiver, transmitter interrupts.
// - Receiver and transmitter output pins can serve as unmasked DMA requests.
// - Address decode produces internal read and write controls through the data buffer.
// - Reading the input change register clears its change flags.
// - Transmit ready drops on holding load and returns when the shifter takes it.
package dui_pkg;

  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 8;
  localparam int NUM_CH  = 2;
  localparam int NUM_CHG = 4;
  localparam int NUM_IP  = 7;
  localparam int NUM_IRQ_PINS = 5;

  localparam logic [ADDR_W-1:0] ADR_CMD_A     = 4'h2;
  localparam logic [ADDR_W-1:0] ADR_HOLD_A    = 4'h3;
  localparam logic [ADDR_W-1:0] ADR_CHG_AUX   = 4'h4;
  localparam logic [ADDR_W-1:0] ADR_STAT_MASK = 4'h5;
  localparam logic [ADDR_W-1:0] ADR_OPCFG     = 4'h6;
  localparam logic [ADDR_W-1:0] ADR_CMD_B     = 4'hA;
  localparam logic [ADDR_W-1:0] ADR_HOLD_B    = 4'hB;
  localparam logic [ADDR_W-1:0] ADR_INPORT    = 4'hD;
  localparam logic [ADDR_W-1:0] ADR_OPSET     = 4'hE;
  localparam logic [ADDR_W-1:0] ADR_OPRST_CT  = 4'hF;

  localparam logic [NUM_CH-1:0][ADDR_W-1:0] CH_HOLD = {ADR_HOLD_B, ADR_HOLD_A};
  localparam logic [NUM_CH-1:0][ADDR_W-1:0] CH_CMD  = {ADR_CMD_B, ADR_CMD_A};

  localparam int CMD_HI = 7;
  localparam int CMD_LO = 4;
  localparam logic [3:0] CMD_BRK_RESET = 4'h5;

  localparam int ISB_TXA = 0;
  localparam int ISB_RXA = 1;
  localparam int ISB_BRKA = 2;
  localparam int ISB_CT  = 3;
  localparam int ISB_TXB = 4;
  localparam int ISB_RXB = 5;
  localparam int ISB_BRKB = 6;
  localparam int ISB_COS = 7;
  localparam logic [NUM_CH-1:0][2:0] CH_TX  = {3'h4, 3'h0};
  localparam logic [NUM_CH-1:0][2:0] CH_RX  = {3'h5, 3'h1};
  localparam logic [NUM_CH-1:0][2:0] CH_BRK = {3'h6, 3'h2};

  // Output pins 3..7 in order: counter, receiver A, receiver B, transmitter A, transmitter B.
  localparam int PIN_FIRST_IRQ = 3;
  localparam logic [NUM_IRQ_PINS-1:0][2:0] PIN_SRC = {3'h4, 3'h0, 3'h5, 3'h1, 3'h3};
  localparam logic [NUM_IRQ_PINS-1:0]      PIN_DMA_OK = 5'h1E;
  localparam logic [NUM_IRQ_PINS-1:0][2:0] PIN_DMA_BIT = {3'h6, 3'h5, 3'h6, 3'h5, 3'h5};

  localparam logic [DATA_W-1:0] UNMAPPED_RD = 8'h00;
  localparam logic              INPORT_TOP  = 1'h1;

  localparam int T_CLK_NS     = 10;
  localparam int T_NEG_MAX_NS = 300;
  localparam int NEG_MAX_CYC  = T_NEG_MAX_NS / T_CLK_NS;
  localparam int T_RES_NS     = 200;
  localparam int RES_MIN_CYC  = (T_RES_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int CMD_GAP_EDGES = 3;

  typedef struct packed {
    logic              rdActive;
    logic              rdStart;
    logic              wrEnd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dui_bus_s;

  typedef struct packed {
    logic [NUM_CH-1:0] rxEvent;
    logic [NUM_CH-1:0] txLoaded;
    logic [NUM_CH-1:0] breakEvent;
    logic              counterZero;
  } dui_evt_s;

  typedef struct packed {
    logic [DATA_W-1:0]  intMask;
    logic [DATA_W-1:0]  auxCtrl;
    logic [DATA_W-1:0]  opcr;
    logic [DATA_W-1:0]  opr;
    logic [DATA_W-1:0]  dout;
    logic               doe;
    logic               intN;
    logic [DATA_W-1:0]  portOut;
    logic [DATA_W-1:0]  portOe;
    logic [NUM_CH-1:0]  tx;
    logic [NUM_CH-1:0]  rx;
    logic [NUM_CH-1:0]  brk;
    logic               ct;
    logic [NUM_CHG-1:0] chg;
    logic [NUM_CHG-1:0] pinPrev;
    logic               primed;
  } dui_state_s;

  localparam dui_state_s STATE_RST = '{intMask: 8'h00, auxCtrl: 8'h00, opcr: 8'h00, opr: 8'h00,
    dout: 8'h00, doe: 1'h0, intN: 1'h1, portOut: 8'hFF, portOe: 8'hFF, tx: 2'h0,
    rx: 2'h0, brk: 2'h0, ct: 1'h0, chg: 4'h0, pinPrev: 4'h0, primed: 1'h0};

endpackage

// ---- logic/dui_top.sv ----
// Host bus front end and interrupt control for a dual-channel serial controller.
// Assumes channel, counter and port sections supply one-cycle event pulses and read data.
`timescale 1ns/1ps
module dui_top (
  input  wire logic                                           clock,
  input  wire logic                                           rst,
  input  wire logic                                           chipSelectN,
  input  wire logic                                           readStrobeN,
  input  wire logic                                           writeStrobeN,
  input  wire logic [dui_pkg::ADDR_W-1:0]                     registerSelect,
  input  wire logic [dui_pkg::DATA_W-1:0]                     dataIn,
  output logic      [dui_pkg::DATA_W-1:0]                     dataOut,
  output logic                                                dataOe,
  input  wire dui_pkg::dui_evt_s                              events,
  input  wire logic [dui_pkg::NUM_CH-1:0][dui_pkg::DATA_W-1:0] receiveHoldingData,
  input  wire logic [dui_pkg::NUM_IP-1:0]                     inputPins,
  output logic                                                interruptRequestN,
  output logic      [dui_pkg::DATA_W-1:0]                     portOut,
  output logic      [dui_pkg::DATA_W-1:0]                     portOe
);

  localparam int NegMaxCyc = dui_pkg::NEG_MAX_CYC;

  dui_pkg::dui_bus_s               bus;
  dui_pkg::dui_state_s             s_q;
  dui_pkg::dui_state_s             s_d;
  logic [dui_pkg::DATA_W-1:0]      statusNow;
  logic [dui_pkg::NUM_IRQ_PINS-1:0] pinAct;
  logic                            changeSummary;

  dui_bus_decode u_dec (
    .clock          (clock),
    .rst            (rst),
    .chipSelectN    (chipSelectN),
    .readStrobeN    (readStrobeN),
    .writeStrobeN   (writeStrobeN),
    .registerSelect (registerSelect),
    .dataIn         (dataIn),
    .bus            (bus)
  );

  // The summary bit hides which pin changed; software reads the change register for that.
  assign changeSummary = |(s_q.chg & s_q.auxCtrl[dui_pkg::NUM_CHG-1:0]);

  always_comb begin
    statusNow = '0;
    for (int c = 0; c < dui_pkg::NUM_CH; c++) begin
      statusNow[dui_pkg::CH_TX[c]]  = s_q.tx[c];
      statusNow[dui_pkg::CH_RX[c]]  = s_q.rx[c];
      statusNow[dui_pkg::CH_BRK[c]] = s_q.brk[c];
    end
    statusNow[dui_pkg::ISB_CT]  = s_q.ct;
    statusNow[dui_pkg::ISB_COS] = changeSummary;
  end

  genvar j;
  generate
    for (j = 0; j < dui_pkg::NUM_IRQ_PINS; j++) begin : g_pin
      // DMA use ignores the mask so the request follows the raw channel condition.
      assign pinAct[j] = (dui_pkg::PIN_DMA_OK[j] && s_q.opcr[dui_pkg::PIN_DMA_BIT[j]])
                       ? statusNow[dui_pkg::PIN_SRC[j]]
                       : statusNow[dui_pkg::PIN_SRC[j]] && s_q.intMask[dui_pkg::PIN_SRC[j]];
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    // Clears come first so an event in the same cycle wins over its clear.
    for (int c = 0; c < dui_pkg::NUM_CH; c++) begin
      if (bus.rdStart && bus.addr == dui_pkg::CH_HOLD[c]) begin
        s_d.rx[c] = 1'b0;
      end
      if (bus.wrEnd && bus.addr == dui_pkg::CH_HOLD[c]) begin
        s_d.tx[c] = 1'b0;
      end
      // Command spacing is left to the host; a too-close second command is not detected.
      if (bus.wrEnd && bus.addr == dui_pkg::CH_CMD[c]
          && bus.wdata[dui_pkg::CMD_HI:dui_pkg::CMD_LO] == dui_pkg::CMD_BRK_RESET) begin
        s_d.brk[c] = 1'b0;
      end
      if (events.rxEvent[c]) begin
        s_d.rx[c] = 1'b1;
      end
      if (events.txLoaded[c]) begin
        s_d.tx[c] = 1'b1;
      end
      if (events.breakEvent[c]) begin
        s_d.brk[c] = 1'b1;
      end
    end
    if (bus.rdStart && bus.addr == dui_pkg::ADR_OPRST_CT) begin
      s_d.ct = 1'b0;
    end
    if (events.counterZero) begin
      s_d.ct = 1'b1;
    end
    if (bus.rdStart && bus.addr == dui_pkg::ADR_CHG_AUX) begin
      s_d.chg = '0;
    end
    s_d.pinPrev = inputPins[dui_pkg::NUM_CHG-1:0];
    s_d.primed  = 1'b1;
    if (s_q.primed) begin
      s_d.chg = s_d.chg | (inputPins[dui_pkg::NUM_CHG-1:0] ^ s_q.pinPrev);
    end
    if (bus.wrEnd) begin
      case (bus.addr)
        dui_pkg::ADR_STAT_MASK: begin
          s_d.intMask = bus.wdata;
        end
        dui_pkg::ADR_CHG_AUX: begin
          s_d.auxCtrl = bus.wdata;
        end
        dui_pkg::ADR_OPCFG: begin
          s_d.opcr = bus.wdata;
        end
        dui_pkg::ADR_OPSET: begin
          s_d.opr = s_q.opr | bus.wdata;
        end
        dui_pkg::ADR_OPRST_CT: begin
          s_d.opr = s_q.opr & ~bus.wdata;
        end
        default: begin
          s_d.opr = s_q.opr;
        end
      endcase
    end
    if (bus.rdStart) begin
      case (bus.addr)
        dui_pkg::ADR_STAT_MASK: begin
          s_d.dout = statusNow;
        end
        dui_pkg::ADR_CHG_AUX: begin
          s_d.dout = {s_q.chg, inputPins[dui_pkg::NUM_CHG-1:0]};
        end
        dui_pkg::ADR_INPORT: begin
          s_d.dout = {dui_pkg::INPORT_TOP, inputPins};
        end
        dui_pkg::ADR_HOLD_A: begin
          s_d.dout = receiveHoldingData[0];
        end
        dui_pkg::ADR_HOLD_B: begin
          s_d.dout = receiveHoldingData[1];
        end
        default: begin
          s_d.dout = dui_pkg::UNMAPPED_RD;
        end
      endcase
    end
    s_d.doe  = bus.rdStart || bus.rdActive;
    s_d.intN = !(|(statusNow & s_q.intMask));
    s_d.portOut = ~s_q.opr;
    s_d.portOe  = '1;
    for (int k = 0; k < dui_pkg::NUM_IRQ_PINS; k++) begin
      if (s_q.opcr[k]) begin
        // Interrupt use makes the pin open drain: it only ever pulls low.
        s_d.portOut[dui_pkg::PIN_FIRST_IRQ + k] = 1'b0;
        s_d.portOe[dui_pkg::PIN_FIRST_IRQ + k]  = pinAct[k];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= dui_pkg::STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign dataOut           = s_q.dout;
  assign dataOe            = s_q.doe;
  assign interruptRequestN = s_q.intN;
  assign portOut           = s_q.portOut;
  assign portOe            = s_q.portOe;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  intr_follows_src_a: assert property (##1 interruptRequestN
      == !(|($past(statusNow) & $past(s_q.intMask))))
    else $error("Request output does not match enabled status.");
  mask_zero_neg_a: assert property (bus.wrEnd && bus.addr == dui_pkg::ADR_STAT_MASK
      && bus.wdata == '0 |-> ##[1:NegMaxCyc] interruptRequestN)
    else $error("Request stayed low after the mask was cleared.");
  rx_clear_a: assert property (bus.rdStart && bus.addr == dui_pkg::ADR_HOLD_A
      && !events.rxEvent[0] |=> !s_q.rx[0])
    else $error("Receive interrupt not cleared by holding register read.");
  tx_clear_a: assert property (bus.wrEnd && bus.addr == dui_pkg::ADR_HOLD_B
      && !events.txLoaded[1] |=> !s_q.tx[1])
    else $error("Transmit ready not cleared by holding register write.");
  tx_reload_a: assert property (events.txLoaded[0] |=> s_q.tx[0])
    else $error("Transmit ready not raised after shifter load.");
  brk_clear_a: assert property (bus.wrEnd && bus.addr == dui_pkg::ADR_CMD_A
      && bus.wdata[dui_pkg::CMD_HI:dui_pkg::CMD_LO] == dui_pkg::CMD_BRK_RESET
      && !events.breakEvent[0] |=> !s_q.brk[0])
    else $error("Break interrupt not cleared by reset command.");
  ct_clear_a: assert property (bus.rdStart && bus.addr == dui_pkg::ADR_OPRST_CT
      && !events.counterZero |=> !s_q.ct)
    else $error("Counter interrupt not cleared by stop command.");
  chg_clear_a: assert property (bus.rdStart && bus.addr == dui_pkg::ADR_CHG_AUX
      && $stable(inputPins[dui_pkg::NUM_CHG-1:0]) |=> s_q.chg == '0)
    else $error("Change flags not cleared by change register read.");
  change_flag_a: assert property (s_q.primed
      && inputPins[dui_pkg::NUM_CHG-1:0] != s_q.pinPrev |=> s_q.chg != '0)
    else $error("Input change not recorded in the change flags.");
  status_read_a: assert property (bus.rdStart && bus.addr == dui_pkg::ADR_STAT_MASK
      |=> dataOut == $past(statusNow) && dataOe)
    else $error("Status read does not show all active conditions.");
  data_release_a: assert property (!bus.rdActive && !bus.rdStart |=> !dataOe)
    else $error("Data bus driven outside a read.");
  mask_after_rst_a: assert property ($past(rst) |-> s_q.intMask == '0 && interruptRequestN)
    else $error("Mask not cleared by reset.");
  pin_ct_a: assert property (s_q.opcr[0] && s_q.ct && s_q.intMask[dui_pkg::ISB_CT]
      |=> portOe[dui_pkg::PIN_FIRST_IRQ] && !portOut[dui_pkg::PIN_FIRST_IRQ])
    else $error("Counter pin not asserted as interrupt.");
  pin_clear_a: assert property (s_q.opcr[0] && !s_q.ct
      |=> !portOe[dui_pkg::PIN_FIRST_IRQ])
    else $error("Counter pin still driven after its flag cleared.");
  dma_rx_pin_a: assert property (s_q.opcr[1] && s_q.opcr[5] && s_q.rx[0]
      |=> portOe[dui_pkg::PIN_FIRST_IRQ + 1])
    else $error("Receiver request pin ignored in DMA use.");

  rx_clear_c: cover property (s_q.rx[0] ##1 !s_q.rx[0]);
  intr_low_c: cover property (interruptRequestN ##1 !interruptRequestN);
  dma_pin_c: cover property (s_q.opcr[1] && s_q.opcr[5] && portOe[4]);
  change_read_c: cover property (changeSummary ##[1:50] bus.rdStart
      && bus.addr == dui_pkg::ADR_CHG_AUX);

endmodule
